// ### logic/pcl_pkg.sv
// constants shared by the port c / port l pin control block
package pcl_pkg;
   // register byte offsets on the plain register port
   localparam logic [3:0] PCL_OFS_C_DATA    = 4'h0; // port_c_data
   localparam logic [3:0] PCL_OFS_C_DIR     = 4'h1; // port_c_direction
   localparam logic [3:0] PCL_OFS_C_PULLUP  = 4'h2; // port_c_pullup_select
   localparam logic [3:0] PCL_OFS_L_DATA    = 4'h3; // port_l_data
   localparam logic [3:0] PCL_OFS_L_DIR     = 4'h4; // port_l_direction
   localparam logic [3:0] PCL_OFS_L_PULLUP  = 4'h5; // port_l_pullup_select
   localparam logic [3:0] PCL_OFS_RST_MODE  = 4'h6; // reset_pin_mode_reg
   localparam logic [3:0] PCL_OFS_OSC_MODE  = 4'h7; // oscillator_mode_select
   localparam logic [3:0] PCL_OFS_ALT_ROUTE = 4'h8; // alt_input_routing
   // field positions
   localparam int PCL_BIT_RST_AS_PORT = 5;  // reset_pin_as_port
   localparam int PCL_BIT_L_OSC1      = 1;  // first oscillator pin
   localparam int PCL_BIT_L_OSC2      = 2;  // second oscillator pin
   localparam int PCL_BIT_L_RST       = 5;  // shared reset pin
   localparam int PCL_BIT_OSC_XTAL    = 0;  // crystal mode
   localparam int PCL_BIT_OSC_EXT     = 1;  // external_clock_in mode
   localparam int PCL_BIT_ALT_EN      = 0;  // alternate routing on
   // reset values
   localparam logic [7:0] PCL_RST_DIR    = 8'hff;
   localparam logic [7:0] PCL_RST_DATA   = 8'h00;
   localparam logic [7:0] PCL_RST_PULLUP = 8'h00;
   localparam logic [7:0] PCL_RST_L_PU   = 8'h20; // reset pin pull-up on
   localparam logic [7:0] PCL_RST_MODE   = 8'h00;
   localparam logic [7:0] PCL_RST_OSC    = 8'h00;
   localparam logic [7:0] PCL_RST_ALT    = 8'h00;
   // writable direction and data bits of port l: the two oscillator pins
   localparam logic [7:0] PCL_L_MASK_IO  = 8'h06;
   // reset-hold states
   typedef enum logic [1:0] {PCL_HOLD, PCL_RUN} pcl_rst_state_t;
endpackage

// ### logic/pcl_sync3.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module pcl_sync3 #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk_sys, // system clock
   input  wire logic             i_rstn,    // sync reset, low
   input  wire logic [WIDTH-1:0] i_async,   // raw pin levels
   input  wire logic [WIDTH-1:0] i_init,    // value held in reset
   output logic      [WIDTH-1:0] o_sync     // filtered levels
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] out_reg;

   // s1 feeds only s2, so metastability never reaches logic
   always_ff @(posedge i_clk_sys) begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end

   // a change counts once stages two and three agree
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         out_reg <= i_init;
      end else begin
         for (int k = 0; k < WIDTH; k++) begin
            if (s2_reg[k] == s3_reg[k]) begin
               out_reg[k] <= s3_reg[k];
            end
         end
      end
   end

   assign o_sync = out_reg;
endmodule // pcl_sync3

// ### logic/pcl_port_ctrl.sv
// pin control for port c (5 bits) and port l (osc pins, reset pin)
`timescale 1ns/1ps
module pcl_port_ctrl
   import pcl_pkg::*;
#(
   parameter int C_WIDTH = 5
) (
   input  wire logic       i_clk_sys,        // 10 MHz system clock
   input  wire logic       i_rstn,           // sync reset, low
   input  wire logic [3:0] i_addr,           // register address
   input  wire logic [7:0] i_wdata,          // write data
   input  wire logic       i_wr,             // write strobe
   input  wire logic       i_rd,             // read strobe
   output logic      [7:0] o_rdata,          // read data, next cycle
   input  wire logic [C_WIDTH-1:0] i_pin_c,  // port c pin levels
   output logic [C_WIDTH-1:0] o_pin_c,       // port c drive value
   output logic [C_WIDTH-1:0] o_pin_c_oe,    // port c drive enable
   output logic [C_WIDTH-1:0] o_pin_c_pu,    // port c pull-up enable
   input  wire logic [2:1] i_pin_l,          // oscillator pin levels
   output logic      [2:1] o_pin_l,          // oscillator drive value
   output logic      [2:1] o_pin_l_oe,       // oscillator drive enable
   output logic      [2:1] o_pin_l_pu,       // oscillator pull-up, tied to zero
   input  wire logic       i_pin_rst,        // shared reset pin level
   output logic            o_pin_rst_pu,     // shared pin pull-up
   output logic            o_ext_reset,      // external reset request
   input  wire logic       i_timer0_output,  // timer0_output from timer
   output logic            o_timer0_capture_in, // routed capture input
   output logic            o_timer0_second_in,  // routed second input
   output logic            o_ext_interrupt_one  // routed interrupt input
);
   // routing needs pins 0..2 to exist, and the masks are only 8 bits wide
   if (C_WIDTH < 3 || C_WIDTH > 8) begin : g_width_check
      $error("pcl_port_ctrl: C_WIDTH must be 3..8");
   end

   localparam logic [7:0] C_MASK = 8'((1 << C_WIDTH) - 1);

   logic [7:0] c_data_reg, c_dir_reg, c_pu_reg;
   logic [7:0] l_data_reg, l_dir_reg, l_pu_reg;
   logic [7:0] rst_mode_reg, osc_mode_reg, alt_reg;
   logic [7:0] rdata_reg;
   logic [C_WIDTH-1:0] c_sync;
   logic [2:0] l_sync;
   pcl_rst_state_t rst_state_reg;
   logic ext_reset_reg;
   logic rst_as_port;
   logic clk_mode;
   logic alt_on;

   assign rst_as_port = rst_mode_reg[PCL_BIT_RST_AS_PORT];
   assign clk_mode = osc_mode_reg[PCL_BIT_OSC_XTAL]
                   | osc_mode_reg[PCL_BIT_OSC_EXT];
   assign alt_on = alt_reg[PCL_BIT_ALT_EN];

   // pin levels synchronised; reset pin starts high so no false reset
   pcl_sync3 #(.WIDTH(C_WIDTH)) u_sync_c (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_async   (i_pin_c),
      .i_init    ({C_WIDTH{1'b0}}),
      .o_sync    (c_sync)
   );
   pcl_sync3 #(.WIDTH(3)) u_sync_l (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_async   ({i_pin_rst, i_pin_l}),
      .i_init    (3'h4),
      .o_sync    (l_sync)
   );

   // write strobe hit on a given offset
   function automatic logic wr_hit(input logic [3:0] ofs);
      return i_wr && (i_addr == ofs);
   endfunction

   // port c registers; direction resets to input
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         c_dir_reg  <= PCL_RST_DIR;
         c_data_reg <= PCL_RST_DATA;
         c_pu_reg   <= PCL_RST_PULLUP;
      end else begin
         // unimplemented bits stay as their reset value
         if (wr_hit(PCL_OFS_C_DIR))
            c_dir_reg <= (i_wdata & C_MASK) | ~C_MASK;
         if (wr_hit(PCL_OFS_C_DATA))
            c_data_reg <= i_wdata & C_MASK;
         if (wr_hit(PCL_OFS_C_PULLUP))
            c_pu_reg <= i_wdata & C_MASK;
      end
   end

   // port l registers; only the oscillator bits are writable directions
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         l_dir_reg  <= PCL_RST_DIR;
         l_data_reg <= PCL_RST_DATA;
         l_pu_reg   <= PCL_RST_L_PU;
      end else begin
         if (wr_hit(PCL_OFS_L_DIR))
            l_dir_reg <= (i_wdata & PCL_L_MASK_IO) | ~PCL_L_MASK_IO;
         if (wr_hit(PCL_OFS_L_DATA))
            l_data_reg <= i_wdata & PCL_L_MASK_IO;
         if (wr_hit(PCL_OFS_L_PULLUP))
            l_pu_reg <= i_wdata & 8'h20;
      end
   end

   // mode, oscillator and routing controls
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rst_mode_reg <= PCL_RST_MODE;
         osc_mode_reg <= PCL_RST_OSC;
         alt_reg      <= PCL_RST_ALT;
      end else begin
         if (wr_hit(PCL_OFS_RST_MODE))
            rst_mode_reg <= i_wdata & 8'h20;
         if (wr_hit(PCL_OFS_OSC_MODE))
            osc_mode_reg <= i_wdata & 8'h03;
         if (wr_hit(PCL_OFS_ALT_ROUTE))
            alt_reg <= i_wdata & 8'h01;
      end
   end

   // reset hold: after release the shared pin is the reset input, and
   // a low level keeps the device in reset until it rises
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rst_state_reg <= PCL_HOLD;
         ext_reset_reg <= 1'b0;
      end else begin
         case (rst_state_reg)
            PCL_HOLD: begin
               ext_reset_reg <= ~l_sync[2];
               if (l_sync[2])
                  rst_state_reg <= PCL_RUN;
            end
            PCL_RUN: begin
               ext_reset_reg <= ~rst_as_port & ~l_sync[2];
               if (~rst_as_port & ~l_sync[2])
                  rst_state_reg <= PCL_HOLD;
            end
            default: rst_state_reg <= PCL_HOLD;
         endcase
      end
   end

   // read data: pin level for inputs, latch for outputs except oscillator pins in a clock mode, which read zero
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rdata_reg <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            PCL_OFS_C_DATA: rdata_reg <= C_MASK &
               ((c_dir_reg & 8'(c_sync)) | (~c_dir_reg & c_data_reg));
            PCL_OFS_C_DIR:    rdata_reg <= c_dir_reg;
            PCL_OFS_C_PULLUP: rdata_reg <= c_pu_reg;
            PCL_OFS_L_DATA: begin
               rdata_reg <= 8'h00;
               rdata_reg[PCL_BIT_L_RST] <= l_sync[2];
               for (int k = 1; k <= 2; k++) begin
                  rdata_reg[k] <= l_dir_reg[k] ? l_sync[k - 1]
                     : (l_data_reg[k] & ~clk_mode);
               end
            end
            PCL_OFS_L_DIR:     rdata_reg <= l_dir_reg;
            PCL_OFS_L_PULLUP:  rdata_reg <= l_pu_reg;
            PCL_OFS_RST_MODE:  rdata_reg <= rst_mode_reg;
            PCL_OFS_OSC_MODE:  rdata_reg <= osc_mode_reg;
            PCL_OFS_ALT_ROUTE: rdata_reg <= alt_reg;
            default:           rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // pin drivers; when routed, port c bit 1 as an output drives the timer output ANDed with its latch bit
   logic [C_WIDTH-1:0] c_oe_reg, c_out_reg, c_pu_out_reg;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         c_oe_reg     <= '0;
         c_out_reg    <= '0;
         c_pu_out_reg <= '0;
      end else begin
         c_oe_reg  <= ~c_dir_reg[C_WIDTH-1:0];
         c_out_reg <= c_data_reg[C_WIDTH-1:0];
         if (alt_on && !c_dir_reg[1])
            c_out_reg[1] <= i_timer0_output & c_data_reg[1];
         // pull-up only on inputs; output pins never pulled
         c_pu_out_reg <= c_pu_reg[C_WIDTH-1:0]
                       & c_dir_reg[C_WIDTH-1:0];
      end
   end

   // oscillator pins are ports only while no clock mode is chosen
   logic [2:1] l_oe_reg, l_out_reg;
   logic       rst_pu_reg;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         l_oe_reg   <= 2'h0;
         l_out_reg  <= 2'h0;
         rst_pu_reg <= 1'b1;
      end else begin
         l_oe_reg  <= ~l_dir_reg[2:1] & {2{~clk_mode}};
         l_out_reg <= l_data_reg[2:1];
         rst_pu_reg <= l_pu_reg[PCL_BIT_L_RST];
      end
   end

   // routed inputs: alternate pins when routing is on, default otherwise
   logic cap_reg, sec_reg, int1_reg;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         cap_reg  <= 1'b0;
         sec_reg  <= 1'b0;
         int1_reg <= 1'b0;
      end else if (alt_on) begin
         // port-mode reset pin wins; else oscillator pin one
         cap_reg  <= rst_as_port ? l_sync[2] : l_sync[0];
         int1_reg <= rst_as_port ? l_sync[2] : l_sync[0];
         sec_reg  <= c_sync[2];
      end else begin
         // default pins on wider packages: port c bits 3 and 4
         cap_reg  <= (C_WIDTH > 3) ? c_sync[3 % C_WIDTH] : 1'b0;
         int1_reg <= (C_WIDTH > 3) ? c_sync[3 % C_WIDTH] : 1'b0;
         sec_reg  <= (C_WIDTH > 4) ? c_sync[4 % C_WIDTH] : 1'b0;
      end
   end

   assign o_rdata             = rdata_reg;
   assign o_pin_c             = c_out_reg;
   assign o_pin_c_oe          = c_oe_reg;
   assign o_pin_c_pu          = c_pu_out_reg;
   assign o_pin_l             = l_out_reg;
   assign o_pin_l_oe          = l_oe_reg;
   assign o_pin_l_pu          = 2'h0;
   assign o_pin_rst_pu        = rst_pu_reg;
   assign o_ext_reset         = ext_reset_reg;
   assign o_timer0_capture_in = cap_reg;
   assign o_timer0_second_in  = sec_reg;
   assign o_ext_interrupt_one = int1_reg;

   // port c drive and pull-up checks; a reset drops any open attempt
   a_c_pull_gate: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (o_pin_c_pu & o_pin_c_oe) == '0)
      else $error("pull-up on driven port c pin");
   a_c_dir_drive: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      wr_hit(PCL_OFS_C_DIR) |->
      ##2 o_pin_c_oe == ~$past(i_wdata[C_WIDTH-1:0], 2))
      else $error("port c enable not from direction write");
   a_c_out_latch: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (wr_hit(PCL_OFS_C_DATA) && !alt_on) |->
      ##2 o_pin_c == $past(i_wdata[C_WIDTH-1:0], 2))
      else $error("port c latch not on pin drive");
   a_c_reset_in: assert property (
      @(posedge i_clk_sys) $rose(i_rstn) |-> o_pin_c_oe == '0)
      else $error("port c driving after reset");
   a_c_pu_reset: assert property (
      @(posedge i_clk_sys) $rose(i_rstn) |-> o_pin_c_pu == '0)
      else $error("port c pull-up on after reset");
   a_alt_timer: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (alt_on && !c_dir_reg[1] && c_data_reg[1]) |=>
      o_pin_c[1] == $past(i_timer0_output))
      else $error("timer output not routed to port c pin");

   // port l checks: a clock mode takes the oscillator pins off the port
   a_l_reset_in: assert property (
      @(posedge i_clk_sys)
      $rose(i_rstn) |-> o_pin_l_oe == 2'h0 && o_pin_rst_pu)
      else $error("port l driving after reset");
   a_l_osc_release: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      clk_mode |=> o_pin_l_oe == 2'h0)
      else $error("oscillator pin driven in clock mode");

   // read path: data stand only in the cycle after the strobe
   a_osc_read_zero: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_rd && i_addr == PCL_OFS_L_DATA && clk_mode
      && l_dir_reg[2:1] == 2'h0) |=> o_rdata[2:1] == 2'h0)
      else $error("oscillator latch read not zero");
   a_rd_idle_zero: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      !i_rd |=> o_rdata == 8'h00)
      else $error("read data outside read slot");
   a_c_dir_ones: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_rd && i_addr == PCL_OFS_C_DIR) |=> (o_rdata | C_MASK) == 8'hff)
      else $error("unused direction bits not read as input");

   // reset pin: a low level in the reset role keeps the request up
   a_rst_hold: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (rst_state_reg == PCL_HOLD && !l_sync[2]) |=> o_ext_reset)
      else $error("reset not held while pin low");
   a_rst_release: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (rst_state_reg == PCL_HOLD && l_sync[2]) |=> !o_ext_reset)
      else $error("reset held after pin rose");
   a_port_no_reset: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (rst_state_reg == PCL_RUN && rst_as_port) |=> !o_ext_reset)
      else $error("reset asserted in port mode");
   a_rst_pull: assert property (
      @(posedge i_clk_sys) disable iff (!i_rstn)
      wr_hit(PCL_OFS_L_PULLUP) |->
      ##2 o_pin_rst_pu == $past(i_wdata[5], 2))
      else $error("reset pin pull-up not from select bit");
   a_mode_reset: assert property (
      @(posedge i_clk_sys) $rose(i_rstn) |-> !rst_as_port && !o_ext_reset)
      else $error("reset pin not in reset role after reset");

   // scenarios worth seeing in a run
   c_dir_write: cover property (@(posedge i_clk_sys)
      wr_hit(PCL_OFS_C_DIR));
   c_port_mode: cover property (@(posedge i_clk_sys)
      $rose(rst_as_port));
   c_ext_reset: cover property (@(posedge i_clk_sys) $rose(o_ext_reset));
   c_alt_route: cover property (@(posedge i_clk_sys) alt_on && rst_as_port);
   c_osc_read: cover property (@(posedge i_clk_sys)
      i_rd && i_addr == PCL_OFS_L_DATA && clk_mode);
endmodule // pcl_port_ctrl

// ### tb/pcl_board.sv
// board side of the package pins: drives levels and resolves each pin
`timescale 1ns/1ps
module pcl_board #(
   parameter int W = 1
) (
   input  wire logic         i_clk_sys, // system clock
   input  wire logic [W-1:0] i_drv,     // device drive value
   input  wire logic [W-1:0] i_oe,      // device drive enable
   input  wire logic [W-1:0] i_pu,      // device pull-up enable
   input  wire logic [W-1:0] i_ext_en,  // board drives the pin
   input  wire logic [W-1:0] i_ext_val, // board drive value
   output logic      [W-1:0] o_level    // resolved pin level
);
   logic [W-1:0] last_reg = '0;

   // device drive wins, then board, then pull-up; a floating pin toggles
   // every cycle so that a stale level can never pass for a real one
   always_comb begin
      for (int b = 0; b < W; b++) begin
         if (i_oe[b])
            o_level[b] = i_drv[b];
         else if (i_ext_en[b])
            o_level[b] = i_ext_val[b];
         else if (i_pu[b])
            o_level[b] = 1'b1;
         else
            o_level[b] = ~last_reg[b];
      end
   end

   // remember the level for the floating case
   always_ff @(posedge i_clk_sys) last_reg <= o_level;
endmodule // pcl_board

// ### tb/pcl_port_ctrl_tb.sv
// self-checking bench for the port c / port l pin control block
`timescale 1ns/1ps
module pcl_port_ctrl_tb;
   import pcl_pkg::*;
   logic       clk, rstn, wr, rd, pin_rst, tout, ext_rst, cap, sec, int1;
   logic       rst_pu, rst_val, rst_en;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d, p, r;
   logic [4:0] c_lvl, c_drv, c_oe, c_pu, c_en, c_val, e;
   logic [2:1] l_lvl, l_drv, l_oe, l_pu, l_en, l_val;
   logic [7:0] exp_q[$];
   logic       rd_seen = 1'b0;
   int         err_total = 0;
   int         check_count = 0;

   pcl_port_ctrl u_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_pin_c(c_lvl), .o_pin_c(c_drv), .o_pin_c_oe(c_oe), .o_pin_c_pu(c_pu),
      .i_pin_l(l_lvl), .o_pin_l(l_drv), .o_pin_l_oe(l_oe), .o_pin_l_pu(l_pu),
      .i_pin_rst(pin_rst), .o_pin_rst_pu(rst_pu), .o_ext_reset(ext_rst),
      .i_timer0_output(tout), .o_timer0_capture_in(cap),
      .o_timer0_second_in(sec), .o_ext_interrupt_one(int1));
   pcl_board #(.W(5)) u_bc (.i_clk_sys(clk), .i_drv(c_drv), .i_oe(c_oe),
      .i_pu(c_pu), .i_ext_en(c_en), .i_ext_val(c_val), .o_level(c_lvl));
   pcl_board #(.W(2)) u_bl (.i_clk_sys(clk), .i_drv(l_drv), .i_oe(l_oe),
      .i_pu(l_pu), .i_ext_en(l_en), .i_ext_val(l_val), .o_level(l_lvl));
   pcl_board #(.W(1)) u_br (.i_clk_sys(clk), .i_drv(1'b0), .i_oe(1'b0),
      .i_pu(rst_pu), .i_ext_en(rst_en), .i_ext_val(rst_val),
      .o_level(pin_rst));

   // 10 MHz system clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one-cycle write strobe; a gap follows so strobes never overlap
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // the expected value is noted before the strobe goes out
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] v);
      exp_q.push_back(v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // wait n edges, then step past the edge so outputs have landed
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_seen)
         chk("rdata", rdata, exp_q.pop_front());
      rd_seen <= rd;
   end

   // hang guard, well beyond the length of the sequence
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      close_out();
   end

   initial begin
      r = 8'($urandom(32'hc583));
      {wr, rd, addr, wdata, tout} = '0;
      {c_en, c_val, l_en, l_val} = '0;
      rst_val = 1'b1;
      rst_en = 1'b1;
      rstn = 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      // reset values, plus one unmapped offset that must read zero
      rd_reg(PCL_OFS_C_DIR, 8'hff);
      rd_reg(PCL_OFS_L_DIR, 8'hff);
      rd_reg(PCL_OFS_C_PULLUP, 8'h00);
      rd_reg(PCL_OFS_L_PULLUP, 8'h20);
      rd_reg(PCL_OFS_RST_MODE, 8'h00);
      rd_reg(PCL_OFS_OSC_MODE, 8'h00);
      rd_reg(PCL_OFS_ALT_ROUTE, 8'h00);
      rd_reg(4'h9, 8'h00);
      #1;
      chk("c_oe", {3'b0, c_oe}, 8'h00);
      chk("rst_pu", {7'b0, rst_pu}, 8'h01);
      chk("ext_rst", {7'b0, ext_rst}, 8'h00);
      // random direction, pull-up and latch; board drives pins without pu
      for (int i = 0; i < 6; i++) begin
         d = 8'($urandom);
         p = 8'($urandom);
         r = 8'($urandom);
         wr_reg(PCL_OFS_C_DIR, d);
         wr_reg(PCL_OFS_C_PULLUP, p);
         wr_reg(PCL_OFS_C_DATA, r);
         c_en <= ~p[4:0];
         c_val <= 5'($urandom);
         settle(6);
         e = (r[4:0] & ~d[4:0]) | (d[4:0] & (p[4:0] | c_val));
         chk("c_oe", {3'b0, c_oe}, {3'b0, ~d[4:0]});
         chk("c_pu", {3'b0, c_pu}, {3'b0, p[4:0] & d[4:0]});
         chk("c_out", {3'b0, c_drv & c_oe}, {3'b0, r[4:0] & ~d[4:0]});
         chk("route", {5'b0, cap, int1, sec},
             {5'b0, c_lvl[3], c_lvl[3], c_lvl[4]});
         rd_reg(PCL_OFS_C_DIR, {3'b111, d[4:0]});
         rd_reg(PCL_OFS_C_DATA, {3'b0, e});
      end
      // oscillator pins as outputs, then in both clock modes
      wr_reg(PCL_OFS_L_DIR, 8'h00);
      wr_reg(PCL_OFS_L_DATA, 8'h06);
      settle(6);
      chk("l_oe", {6'b0, l_oe}, 8'h03);
      chk("l_out", {6'b0, l_drv}, 8'h03);
      rd_reg(PCL_OFS_L_DIR, 8'hf9);
      rd_reg(PCL_OFS_L_DATA, 8'h26);
      for (int m = 1; m < 3; m++) begin
         wr_reg(PCL_OFS_OSC_MODE, 8'(m));
         rd_reg(PCL_OFS_L_DATA, 8'h20);
      end
      wr_reg(PCL_OFS_OSC_MODE, 8'h00);
      // shared pin in reset role: a low level requests reset
      rst_val <= 1'b0;
      settle(6);
      chk("ext_rst", {7'b0, ext_rst}, 8'h01);
      @(posedge clk);
      rst_val <= 1'b1;
      settle(6);
      chk("ext_rst", {7'b0, ext_rst}, 8'h00);
      // port role: low level is plain data, pull-up follows its select
      wr_reg(PCL_OFS_RST_MODE, 8'h20);
      wr_reg(PCL_OFS_L_PULLUP, 8'h00);
      rst_val <= 1'b0;
      settle(6);
      chk("ext_rst", {7'b0, ext_rst}, 8'h00);
      chk("rst_pu", {7'b0, rst_pu}, 8'h00);
      rd_reg(PCL_OFS_L_DATA, 8'h06);
      // alternate routing on: capture from shared pin, timer out on c1
      wr_reg(PCL_OFS_ALT_ROUTE, 8'h01);
      wr_reg(PCL_OFS_C_DIR, 8'hfd);
      wr_reg(PCL_OFS_C_DATA, 8'h02);
      c_en <= 5'h1f;
      for (int i = 0; i < 4; i++) begin
         rst_val <= i[0];
         tout <= i[1];
         c_val <= 5'($urandom);
         settle(6);
         chk("cap", {6'b0, cap, int1}, {6'b0, rst_val, rst_val});
         chk("sec", {7'b0, sec}, {7'b0, c_lvl[2]});
         chk("tmr", {7'b0, c_drv[1]}, {7'b0, tout});
         @(posedge clk);
      end
      // reset while the pin is low: reset state held until it rises
      rst_val <= 1'b0;
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      settle(8);
      chk("ext_rst", {7'b0, ext_rst}, 8'h01);
      rd_reg(PCL_OFS_RST_MODE, 8'h00);
      rd_reg(PCL_OFS_L_PULLUP, 8'h20);
      rd_reg(PCL_OFS_L_DIR, 8'hff);
      // board lets go of the pin: only its pull-up can bring it high
      @(posedge clk);
      rst_en <= 1'b0;
      settle(6);
      chk("ext_rst", {7'b0, ext_rst}, 8'h00);
      // routing on with the pin in reset role: inputs from oscillator pin
      wr_reg(PCL_OFS_ALT_ROUTE, 8'h01);
      l_en <= 2'h3;
      l_val <= 2'($urandom);
      settle(6);
      chk("l_pu", {6'b0, l_pu}, 8'h00);
      chk("cap_l", {6'b0, cap, int1}, {6'b0, l_lvl[1], l_lvl[1]});
      rd_reg(PCL_OFS_L_DATA, {2'b0, 1'b1, 2'b0, l_val, 1'b0});
      settle(2);
      close_out();
   end
endmodule // pcl_port_ctrl_tb
